// [rtl/rsc_pkg.sv]
package rsc_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;

  // Clock-loss one-shot timeout
  localparam int unsigned MISS_TIME_US = 100;
  localparam int unsigned MISS_CYCLES = MISS_TIME_US * CLK_MHZ;
  localparam int unsigned MISS_WIDTH = 16;

  // Least time the reset output is held once a cause is seen, rounded up
  localparam int unsigned HOLD_TIME_NS = 320;
  localparam int unsigned HOLD_CYCLES = (HOLD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_WIDTH = 8;

  // Watchdog time base and default span
  localparam int unsigned WD_DIV = 12;
  localparam int unsigned WD_DIV_WIDTH = 4;
  localparam int unsigned WD_WIDTH = 16;
  localparam int unsigned WD_LIMIT = 16'hFFFF;

  // Highest legal user code address
  localparam logic [15:0] USER_CODE_TOP = 16'h3DFF;

  // Reset-source register layout
  localparam int unsigned PIN_BIT = 0;
  localparam int unsigned LOSS_BIT = 2;
  localparam int unsigned WD_BIT = 3;
  localparam int unsigned CMP_BIT = 5;
  localparam int unsigned FERR_BIT = 6;
  localparam logic [7:0] SRC_RESET = 8'h00;
  localparam logic LOSS_EN_RESET = 1'b0;
  localparam logic CMP_ARM_RESET = 1'b0;

  typedef enum logic [0:0] {
    RSC_RUN,
    RSC_HOLD
  } rsc_phase_t;

  typedef struct packed {
    logic move_write;
    logic write_allow;
    logic [15:0] move_addr;
    logic code_read;
    logic [15:0] code_addr;
    logic fetch;
    logic [15:0] fetch_addr;
    logic security_block;
  } rsc_flash_req_t;

  typedef struct packed {
    logic pin;
    logic loss;
    logic ferr;
    logic wd;
    logic cmp;
  } rsc_cause_t;

  function automatic logic rsc_above_user(input logic [15:0] addr);
    rsc_above_user = addr > USER_CODE_TOP;
  endfunction

endpackage

// [rtl/rsc_watchdog.sv]
`timescale 1ns/1ps
`default_nettype none
module rsc_watchdog #(
  parameter int unsigned WIDTH = rsc_pkg::WD_WIDTH,
  parameter logic [WIDTH-1:0] LIMIT = WIDTH'(rsc_pkg::WD_LIMIT)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sys_reset,
  input wire logic enable_req,
  input wire logic disable_req,
  input wire logic service,
  output logic enabled,
  output logic expire
);

  if (WIDTH < 2 || LIMIT == '0) begin : g_chk
    $error("rsc_watchdog: WIDTH or LIMIT out of range");
  end

  typedef struct packed {
    logic [rsc_pkg::WD_DIV_WIDTH-1:0] pre;
    logic [WIDTH-1:0] count;
    logic enabled;
    logic expire;
  } rsc_wd_state_t;

  rsc_wd_state_t s;
  rsc_wd_state_t next_s;
  logic tick;

  always_comb begin
    next_s = s;
    next_s.expire = 1'b0;
    tick = s.pre == rsc_pkg::WD_DIV_WIDTH'(rsc_pkg::WD_DIV - 1);
    if (tick) begin
      next_s.pre = '0;
    end else begin
      next_s.pre = s.pre + 1'b1;
    end
    if (disable_req) begin
      next_s.enabled = 1'b0;
      next_s.count = '0;
    end else if (enable_req) begin
      next_s.enabled = 1'b1;
    end
    if (service) begin
      next_s.count = '0;
    end else if (s.enabled && tick) begin
      if (s.count == LIMIT) begin
        next_s.expire = 1'b1;
        next_s.count = '0;
      end else begin
        next_s.count = s.count + 1'b1;
      end
    end
    // Any reset leaves the watchdog running on the divided clock
    if (sys_reset) begin
      next_s.pre = '0;
      next_s.count = '0;
      next_s.enabled = 1'b1;
      next_s.expire = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '{pre: '0, count: '0, enabled: 1'b1, expire: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign enabled = s.enabled;
  assign expire = s.expire;

endmodule
`default_nettype wire

// [rtl/rsc_reset_source.sv]
// Functional notes
// - Low external reset pin forces reset
// - Pin flag set when pin reset ends
// - Clock gap over 100 us resets
// - Clock-loss flag reads 1 only after it
// - Write bit 2 enables or disables monitor
// - Internal resets never drive the pin
// - Write 1 to bit 5 arms comparator
// - Armed comparator low output causes reset
// - Comparator flag reads 1 only after it
// - Disabled comparator never causes reset
// - Watchdog enabled, core clock over 12, after reset (here it divides clk by 12, not the core clock)
// - Watchdog expiry resets, sets its flag
// - Allowed move write above 3DFF resets
// - Code read above 3DFF resets
// - Fetch or branch above 3DFF resets
// - Security-forbidden flash access resets
// - Flash error reset sets bit 6 flag
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source #(
  parameter int unsigned MISS_CYCLES = rsc_pkg::MISS_CYCLES,
  parameter int unsigned HOLD_CYCLES = rsc_pkg::HOLD_CYCLES,
  parameter int unsigned WD_WIDTH = rsc_pkg::WD_WIDTH,
  parameter logic [WD_WIDTH-1:0] WD_LIMIT = WD_WIDTH'(rsc_pkg::WD_LIMIT)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ext_reset_n,
  input wire logic core_clock_edge,
  input wire logic comparator_out,
  input wire logic comparator_enabled,
  input wire rsc_pkg::rsc_flash_req_t flash_req,
  input wire logic wd_enable_req,
  input wire logic wd_disable_req,
  input wire logic wd_service,
  input wire logic src_write,
  input wire logic [7:0] src_write_data,
  output logic [7:0] reset_source_register,
  output logic clock_loss_monitor_en,
  output logic comparator_armed,
  output logic watchdog_enabled,
  output logic system_reset
);

  if (MISS_CYCLES < 2 || MISS_CYCLES >= (1 << rsc_pkg::MISS_WIDTH)) begin : g_chk_miss
    $error("rsc_reset_source: MISS_CYCLES out of range");
  end
  if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << rsc_pkg::HOLD_WIDTH)) begin : g_chk_hold
    $error("rsc_reset_source: HOLD_CYCLES out of range");
  end

  typedef struct packed {
    rsc_pkg::rsc_phase_t phase;
    logic [rsc_pkg::HOLD_WIDTH-1:0] hold_cnt;
    rsc_pkg::rsc_cause_t cause;
    logic [7:0] flags;
    logic loss_en;
    logic cmp_arm;
    logic [rsc_pkg::MISS_WIDTH-1:0] miss_cnt;
    logic in_reset;
  } rsc_state_t;

  localparam logic [rsc_pkg::MISS_WIDTH-1:0] MISS_LAST =
    rsc_pkg::MISS_WIDTH'(MISS_CYCLES - 1);
  localparam logic [rsc_pkg::HOLD_WIDTH-1:0] HOLD_LAST =
    rsc_pkg::HOLD_WIDTH'(HOLD_CYCLES - 1);

  rsc_state_t s;
  rsc_state_t next_s;
  rsc_pkg::rsc_cause_t req;
  logic flash_bad;
  logic wd_expire;

  // One flag only, chosen by priority when causes coincide
  function automatic logic [7:0] rsc_flags(input rsc_pkg::rsc_cause_t c);
    logic [7:0] f;
    f = 8'h00;
    if (c.pin) begin
      f[rsc_pkg::PIN_BIT] = 1'b1;
    end else if (c.loss) begin
      f[rsc_pkg::LOSS_BIT] = 1'b1;
    end else if (c.ferr) begin
      f[rsc_pkg::FERR_BIT] = 1'b1;
    end else if (c.wd) begin
      f[rsc_pkg::WD_BIT] = 1'b1;
    end else if (c.cmp) begin
      f[rsc_pkg::CMP_BIT] = 1'b1;
    end
    return f;
  endfunction

  rsc_watchdog #(
    .WIDTH(WD_WIDTH),
    .LIMIT(WD_LIMIT)
  ) u_watchdog (
    .clk(clk),
    .rstn(rstn),
    .sys_reset(s.in_reset),
    .enable_req(wd_enable_req),
    .disable_req(wd_disable_req),
    .service(wd_service),
    .enabled(watchdog_enabled),
    .expire(wd_expire)
  );

  always_comb begin
    flash_bad = 1'b0;
    if (flash_req.move_write && flash_req.write_allow &&
        rsc_pkg::rsc_above_user(flash_req.move_addr)) begin
      flash_bad = 1'b1;
    end
    if (flash_req.code_read && rsc_pkg::rsc_above_user(flash_req.code_addr)) begin
      flash_bad = 1'b1;
    end
    if (flash_req.fetch && rsc_pkg::rsc_above_user(flash_req.fetch_addr)) begin
      flash_bad = 1'b1;
    end
    if (flash_req.security_block) begin
      flash_bad = 1'b1;
    end
  end

  always_comb begin
    req.pin = !ext_reset_n;
    // A stopped core clock shows as missing edge strobes in this domain
    req.loss = s.loss_en && !core_clock_edge && s.miss_cnt == MISS_LAST;
    req.ferr = flash_bad;
    req.wd = wd_expire;
    // Chatter is not filtered; arming a settled comparator is up to software
    req.cmp = s.cmp_arm && comparator_enabled && !comparator_out;
  end

  always_comb begin
    next_s = s;
    unique case (s.phase)
      rsc_pkg::RSC_RUN: begin
        if (!s.loss_en || core_clock_edge) begin
          next_s.miss_cnt = '0;
        end else if (s.miss_cnt != MISS_LAST) begin
          next_s.miss_cnt = s.miss_cnt + 1'b1;
        end
        if (src_write) begin
          next_s.loss_en = src_write_data[rsc_pkg::LOSS_BIT];
          next_s.cmp_arm = src_write_data[rsc_pkg::CMP_BIT];
        end
        if (|req) begin
          next_s.phase = rsc_pkg::RSC_HOLD;
          next_s.cause = req;
          next_s.hold_cnt = '0;
          next_s.in_reset = 1'b1;
          next_s.miss_cnt = '0;
        end
      end
      rsc_pkg::RSC_HOLD: begin
        if (req.pin) begin
          next_s.cause.pin = 1'b1;
        end
        if (s.hold_cnt != HOLD_LAST) begin
          next_s.hold_cnt = s.hold_cnt + 1'b1;
        end else if (ext_reset_n) begin
          // Flags change only on exit so software sees the cause of this reset
          next_s.phase = rsc_pkg::RSC_RUN;
          next_s.flags = rsc_flags(s.cause);
          next_s.cause = '0;
          next_s.in_reset = 1'b0;
          next_s.loss_en = rsc_pkg::LOSS_EN_RESET;
          next_s.cmp_arm = rsc_pkg::CMP_ARM_RESET;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      // Power-on runs one normal hold, so the core leaves reset with no cause flag set
      s <= '{phase: rsc_pkg::RSC_HOLD, hold_cnt: '0, cause: '0,
             flags: rsc_pkg::SRC_RESET, loss_en: rsc_pkg::LOSS_EN_RESET,
             cmp_arm: rsc_pkg::CMP_ARM_RESET, miss_cnt: '0, in_reset: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // The pin is input only here; internal causes reach only system_reset
  assign system_reset = s.in_reset;
  assign reset_source_register = s.flags;
  assign clock_loss_monitor_en = s.loss_en;
  assign comparator_armed = s.cmp_arm;

endmodule
`default_nettype wire

// [sim/rsc_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rsc_far_model (
  input wire logic clk,
  input wire logic clk_run,
  input wire logic svc_on,
  output logic core_clock_edge,
  output logic wd_service
);
  logic edge_q = 1'b1;
  logic kick_q = 1'b0;
  logic [2:0] cnt = 3'h0;
  assign core_clock_edge = edge_q;
  assign wd_service = kick_q;
  always @(posedge clk) begin
    // No strobes while stopped, as a dead oscillator gives none
    edge_q <= clk_run;
    cnt <= cnt + 3'h1;
    // Kick well inside the watchdog span so only a deliberate stop expires it
    kick_q <= svc_on && cnt == 3'h0;
  end
endmodule
`default_nettype wire

// [sim/rsc_reset_source_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_monitor #(
  parameter int unsigned MISS_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ext_reset_n,
  input wire logic core_clock_edge,
  input wire logic comparator_out,
  input wire logic comparator_enabled,
  input wire rsc_pkg::rsc_flash_req_t flash_req,
  input wire logic src_write,
  input wire logic [7:0] src_write_data,
  input wire logic [7:0] reset_source_register,
  input wire logic clock_loss_monitor_en,
  input wire logic comparator_armed,
  input wire logic watchdog_enabled,
  input wire logic system_reset
);
  logic fb;
  logic [15:0] gap;
  logic por_done;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  assign fb = (flash_req.move_write && flash_req.write_allow && flash_req.move_addr > 16'h3DFF)
    || (flash_req.code_read && flash_req.code_addr > 16'h3DFF)
    || (flash_req.fetch && flash_req.fetch_addr > 16'h3DFF) || flash_req.security_block;
  always_ff @(posedge clk) begin
    if (!rstn || core_clock_edge || !clock_loss_monitor_en || system_reset) begin
      gap <= 16'h0000;
    end else begin
      gap <= gap + 16'h0001;
    end
  end
  // The first exit after power-on has no cause, so it is checked apart
  always_ff @(posedge clk) begin
    if (!rstn) begin
      por_done <= 1'b0;
    end else if (!system_reset) begin
      por_done <= 1'b1;
    end
  end
  AST_PIN: assert property (!ext_reset_n |-> ##[1:2] system_reset)
    else $error("pin reset missed");
  AST_CMP: assert property (comparator_armed && comparator_enabled &&
    !comparator_out && !system_reset |-> ##[1:2] system_reset) else $error("cmp reset missed");
  AST_FERR: assert property (fb && !system_reset |-> ##[1:2] system_reset)
    else $error("flash reset missed");
  AST_HOLD: assert property ($rose(system_reset) |-> system_reset[*2])
    else $error("reset too short");
  AST_ONE: assert property ($fell(system_reset) && por_done |->
    $onehot(reset_source_register)) else $error("flags not one-hot");
  AST_POR: assert property ($fell(system_reset) && !por_done |->
    reset_source_register == 8'h00) else $error("flags set after power-on");
  AST_SRCW: assert property (src_write && !system_reset |=>
    clock_loss_monitor_en == $past(src_write_data[2]) && comparator_armed == $past(src_write_data[5]))
    else $error("enable write lost");
  AST_CLR: assert property ($fell(system_reset) |-> !clock_loss_monitor_en && !comparator_armed)
    else $error("enables kept");
  AST_WDON: assert property ($fell(system_reset) |-> watchdog_enabled)
    else $error("watchdog off after reset");
  AST_LOSS: assert property (gap <= 16'(MISS_CYCLES + 2))
    else $error("clock loss missed");
endmodule
bind rsc_reset_source rsc_reset_source_monitor #(.MISS_CYCLES(MISS_CYCLES)) u_mon (
  .clk(clk), .rstn(rstn), .ext_reset_n(ext_reset_n), .core_clock_edge(core_clock_edge),
  .comparator_out(comparator_out), .comparator_enabled(comparator_enabled),
  .flash_req(flash_req), .src_write(src_write), .src_write_data(src_write_data),
  .reset_source_register(reset_source_register), .clock_loss_monitor_en(clock_loss_monitor_en),
  .comparator_armed(comparator_armed), .watchdog_enabled(watchdog_enabled),
  .system_reset(system_reset)
);
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rstn, ext_n, edge_s, cmp_out, cmp_en, wd_en_req, wd_dis_req, wd_svc;
  logic src_write, clk_run, svc_on, loss_en, cmp_arm, wd_en, system_reset;
  logic [7:0] src_write_data, rsr;
  rsc_pkg::rsc_flash_req_t flash_req;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int wait_n = 0;
  rsc_reset_source #(.MISS_CYCLES(20), .HOLD_CYCLES(2), .WD_LIMIT(16'h0003)) u_dut (
    .clk(clk), .rstn(rstn), .ext_reset_n(ext_n), .core_clock_edge(edge_s),
    .comparator_out(cmp_out), .comparator_enabled(cmp_en), .flash_req(flash_req),
    .wd_enable_req(wd_en_req), .wd_disable_req(wd_dis_req), .wd_service(wd_svc),
    .src_write(src_write), .src_write_data(src_write_data), .reset_source_register(rsr),
    .clock_loss_monitor_en(loss_en), .comparator_armed(cmp_arm), .watchdog_enabled(wd_en),
    .system_reset(system_reset)
  );
  rsc_far_model u_far (.clk(clk), .clk_run(clk_run), .svc_on(svc_on),
    .core_clock_edge(edge_s), .wd_service(wd_svc));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      test_done;
    end
  end
  task test_done;
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wait_rst(input logic [7:0] e);
    int n;
    n = 0;
    while (system_reset !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    while (system_reset !== 1'b0 && n < 300) begin
      tick(1);
      n++;
    end
    if (n >= 300) begin
      fails++;
      $display("Error at %0t: reset wait timed out", $time);
    end
    chk(rsr, e);
  endtask
  task wr(input logic [7:0] d);
    src_write = 1'b1;
    src_write_data = d;
    tick(1);
    src_write = 1'b0;
  endtask
  task ftry(input rsc_pkg::rsc_flash_req_t r, input logic bad);
    flash_req = r;
    tick(1);
    flash_req = '0;
    if (bad) begin
      wait_rst(8'h40);
    end else begin
      tick(4);
      chk({7'h0, system_reset}, 8'h00);
    end
  endtask
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ext_n = 1'b1;
    cmp_out = 1'b1;
    cmp_en = 1'b0;
    wd_en_req = 1'b0;
    wd_dis_req = 1'b0;
    src_write = 1'b0;
    src_write_data = 8'h00;
    flash_req = '0;
    clk_run = 1'b1;
    svc_on = 1'b1;
    tick(20);
    rstn = 1'b1;
    wait_rst(8'h00);
    ext_n = 1'b0;
    tick(3);
    ext_n = 1'b1;
    wait_rst(8'h01);
    wr(8'h04);
    chk({7'h0, loss_en}, 8'h01);
    clk_run = 1'b0;
    wait_rst(8'h04);
    clk_run = 1'b1;
    cmp_out = 1'b0;
    wr(8'h20);
    chk({7'h0, cmp_arm}, 8'h01);
    tick(6);
    chk({7'h0, system_reset}, 8'h00);
    cmp_en = 1'b1;
    wait_rst(8'h20);
    cmp_out = 1'b1;
    wr(8'h20);
    tick(6);
    chk({7'h0, system_reset}, 8'h00);
    ftry({2'b11, 16'h3E00, 35'h0}, 1'b1);
    ftry({2'b11, 16'h3DFF, 35'h0}, 1'b0);
    ftry({2'b10, 16'hFFFF, 35'h0}, 1'b0);
    ftry({18'h0, 1'b1, 16'h3DFF, 18'h0}, 1'b0);
    ftry({18'h0, 1'b1, 16'h3E00, 18'h0}, 1'b1);
    ftry({35'h0, 1'b1, 16'h3DFF, 1'b0}, 1'b0);
    ftry({35'h0, 1'b1, 16'hFFFF, 1'b0}, 1'b1);
    ftry({52'h0, 1'b1}, 1'b1);
    wd_dis_req = 1'b1;
    tick(1);
    wd_dis_req = 1'b0;
    svc_on = 1'b0;
    tick(120);
    chk({6'h0, wd_en, system_reset}, 8'h00);
    wd_en_req = 1'b1;
    tick(1);
    wd_en_req = 1'b0;
    chk({7'h0, wd_en}, 8'h01);
    wait_rst(8'h08);
    ext_n = 1'b0;
    tick(3);
    ext_n = 1'b1;
    wait_rst(8'h01);
    chk({7'h0, wd_en}, 8'h01);
    // Four ticks of 12 cycles reach the limit; one more edge registers the reset
    while (system_reset !== 1'b1 && wait_n < 300) begin
      tick(1);
      wait_n++;
    end
    chk(wait_n[7:0], 8'h31);
    wait_rst(8'h08);
    test_done;
  end
endmodule
`default_nettype wire
